// *** logic/clkm_ctrl.sv ***
// Clock multiplier control register, lock sequencing and system clock choice
`default_nettype none
// Operation
// - The multiplier runs its selected 12 MHz reference at four times, giving 48 MHz.
// - A halved copy of the multiplier output can be chosen as the system clock.
// - Where the variant allows it, the full 48 MHz output can be chosen as system clock.
// - Bits 1-0 choose internal, external or halved external reference; code 11 is reserved.
// - Read-only bit 5 reads 1 only once the output is stable; software polls for it.
// - Bit 7 switches the multiplier off or on, and the register resets to all zeros.
module clkm_ctrl #(
    parameter int LOCK_CYCLES   = clkm_pkg::LOCK_CYCLES,
    parameter bit FULL_SYSCLK_EN = 1'b1
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic [1:0] sysclk_req_i,
    output logic            mul_on_o,
    output logic      [1:0] mul_ref_sel_o,
    output logic            mul_ref_half_o,
    output logic      [2:0] mul_factor_o,
    output logic            mul_locked_o,
    output logic      [1:0] sysclk_mul_sel_o
);
    generate
        if (LOCK_CYCLES < 2 || LOCK_CYCLES > 1000) begin : g_bad
            $error("clkm_ctrl: LOCK_CYCLES out of range");
        end
    endgenerate

    clkm_lock_if lk ();

    clkm_lock_timer #(.CYCLES(LOCK_CYCLES)) u_timer (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .lk        (lk.timer)
    );

    function automatic logic src_valid(input logic [1:0] sel);
        src_valid = (sel != clkm_pkg::SRC_RESERVED);
    endfunction

    logic                       on_ff;
    logic                       nxt_on;
    logic                       init_ff;
    logic                       nxt_init;
    logic [1:0]                 sel_ff;
    logic [1:0]                 nxt_sel;
    clkm_pkg::clkm_state_type   state_ff;
    clkm_pkg::clkm_state_type   nxt_state;
    logic [7:0]                 rdata_ff;
    logic [7:0]                 nxt_rdata;
    logic [1:0]                 sys_ff;
    logic [1:0]                 nxt_sys;
    logic                       wr_hit;
    logic                       init_req;
    logic                       start_c;
    logic                       abort_c;

    assign wr_hit = sfr_wr_i && (sfr_addr_i == clkm_pkg::CTRL_ADDR);
    // Init takes effect only once the multiplier was already on
    assign init_req = wr_hit && sfr_wdata_i[clkm_pkg::INIT_BIT]
                      && sfr_wdata_i[clkm_pkg::ON_BIT] && on_ff
                      && src_valid(sfr_wdata_i[1:0]);

    // Register fields
    always_comb begin
        nxt_on   = on_ff;
        nxt_init = init_ff;
        nxt_sel  = sel_ff;
        if (wr_hit) begin
            nxt_on   = sfr_wdata_i[clkm_pkg::ON_BIT];
            nxt_init = sfr_wdata_i[clkm_pkg::INIT_BIT];
            nxt_sel  = sfr_wdata_i[clkm_pkg::SEL_LSB +: clkm_pkg::SEL_W];
        end
    end

    // Lock sequencing
    always_comb begin
        nxt_state = state_ff;
        start_c   = 1'b0;
        abort_c   = 1'b0;
        if (!nxt_on) begin
            nxt_state = clkm_pkg::ST_OFF;
            abort_c   = 1'b1;
        end else begin
            case (state_ff)
                clkm_pkg::ST_OFF: begin
                    nxt_state = clkm_pkg::ST_ARMED;
                end
                clkm_pkg::ST_ARMED, clkm_pkg::ST_LOCKED: begin
                    if (init_req) begin
                        nxt_state = clkm_pkg::ST_LOCKING;
                        start_c   = 1'b1;
                    end
                end
                clkm_pkg::ST_LOCKING: begin
                    if (init_req) begin
                        start_c = 1'b1;
                    end else if (lk.done) begin
                        nxt_state = clkm_pkg::ST_LOCKED;
                    end
                end
                default: begin
                    nxt_state = clkm_pkg::ST_OFF;
                    abort_c   = 1'b1;
                end
            endcase
        end
    end

    assign lk.start = start_c;
    assign lk.abort = abort_c;

    // Read-back and system clock selection
    always_comb begin
        nxt_rdata = 8'h00;
        if (sfr_addr_i == clkm_pkg::CTRL_ADDR) begin
            nxt_rdata[clkm_pkg::ON_BIT]     = on_ff;
            nxt_rdata[clkm_pkg::INIT_BIT]   = init_ff;
            nxt_rdata[clkm_pkg::LOCKED_BIT] = (state_ff == clkm_pkg::ST_LOCKED);
            nxt_rdata[clkm_pkg::SEL_LSB +: clkm_pkg::SEL_W] = sel_ff;
        end
        case (sysclk_req_i)
            clkm_pkg::SYS_REQ_HALF: nxt_sys = clkm_pkg::SYS_SEL_HALF;
            clkm_pkg::SYS_REQ_FULL: nxt_sys = FULL_SYSCLK_EN ? clkm_pkg::SYS_SEL_FULL
                                                             : clkm_pkg::SYS_SEL_NONE;
            default:                nxt_sys = clkm_pkg::SYS_SEL_NONE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            on_ff    <= clkm_pkg::CTRL_RESET[clkm_pkg::ON_BIT];
            init_ff  <= clkm_pkg::CTRL_RESET[clkm_pkg::INIT_BIT];
            sel_ff   <= clkm_pkg::CTRL_RESET[1:0];
            state_ff <= clkm_pkg::ST_OFF;
            rdata_ff <= 8'h00;
            sys_ff   <= clkm_pkg::SYS_SEL_NONE;
        end else begin
            on_ff    <= nxt_on;
            init_ff  <= nxt_init;
            sel_ff   <= nxt_sel;
            state_ff <= nxt_state;
            rdata_ff <= nxt_rdata;
            sys_ff   <= nxt_sys;
        end
    end

    assign sfr_rdata_o      = rdata_ff;
    assign mul_on_o         = on_ff;
    assign mul_ref_sel_o    = sel_ff;
    assign mul_ref_half_o   = (sel_ff == clkm_pkg::SRC_EXT_HALF);
    assign mul_factor_o     = clkm_pkg::MUL_FACTOR;
    assign mul_locked_o     = (state_ff == clkm_pkg::ST_LOCKED);
    assign sysclk_mul_sel_o = sys_ff;

    // Done pulse is one edge before the locked state is registered
    localparam int LockA = LOCK_CYCLES + 1;

    a_zero_write_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_hit && sfr_wdata_i == 8'h00 |=> !mul_on_o && !mul_locked_o)
        else $error("zero write did not reset multiplier");
    a_off_no_lock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !mul_on_o |-> !mul_locked_o)
        else $error("locked while disabled");
    sequence s_init_seen;
        init_req && state_ff != clkm_pkg::ST_OFF;
    endsequence
    a_lock_delay: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_init_seen |=> !mul_locked_o [*2])
        else $error("locked too early after init");
    a_lock_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_init_seen ##1 (mul_on_o && !init_req) [*1] |-> ##[0:LockA] mul_locked_o || !mul_on_o
        || init_req)
        else $error("lock not reached in time");
    a_lock_needs_on: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(mul_locked_o) |-> $past(mul_on_o) && mul_on_o)
        else $error("lock rose without enable");
    a_rdata_ready: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sfr_addr_i == clkm_pkg::CTRL_ADDR |=> sfr_rdata_o[5] == $past(mul_locked_o))
        else $error("ready bit readback wrong");
    a_half_ref: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_hit |=> mul_ref_half_o == ($past(sfr_wdata_i[1:0]) == clkm_pkg::SRC_EXT_HALF))
        else $error("halved reference flag wrong");
    a_sys_half: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sysclk_req_i == clkm_pkg::SYS_REQ_HALF |=> sysclk_mul_sel_o == clkm_pkg::SYS_SEL_HALF)
        else $error("halved system clock not selected");
    a_reserved_src: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_hit && sfr_wdata_i[1:0] == clkm_pkg::SRC_RESERVED && !mul_locked_o
        |=> !mul_locked_o)
        else $error("reserved source started lock");
endmodule
`default_nettype wire

// *** logic/clkm_lock_if.sv ***
// Handshake between the control state machine and the lock timer
`default_nettype none
interface clkm_lock_if;
    logic start;
    logic abort;
    logic done;
    modport ctrl  (output start, output abort, input done);
    modport timer (input start, input abort, output done);
endinterface
`default_nettype wire

// *** logic/clkm_lock_timer.sv ***
// Lock settling timer: pulses done a fixed number of cycles after start
`default_nettype none
module clkm_lock_timer #(
    parameter int CYCLES = clkm_pkg::LOCK_CYCLES
) (
    input  wire logic     sys_clk_i,
    input  wire logic     reset_i,
    clkm_lock_if.timer    lk
);
    generate
        if (CYCLES < 2 || CYCLES > 65535) begin : g_bad
            $error("clkm_lock_timer: CYCLES out of range");
        end
    endgenerate

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        run_ff;
    logic        nxt_run;
    logic        done_ff;
    logic        nxt_done;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_run  = run_ff;
        nxt_done = 1'b0;
        if (lk.abort) begin
            nxt_run = 1'b0;
            nxt_cnt = 16'h0000;
        end else if (lk.start) begin
            nxt_run = 1'b1;
            nxt_cnt = 16'h0000;
        end else if (run_ff) begin
            if (cnt_ff == 16'(CYCLES - 2)) begin
                nxt_run  = 1'b0;
                nxt_done = 1'b1;
            end
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cnt_ff  <= 16'h0000;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            run_ff  <= nxt_run;
            done_ff <= nxt_done;
        end
    end

    assign lk.done = done_ff;
endmodule
`default_nettype wire

// *** logic/clkm_pkg.sv ***
// Constants shared by the clock multiplier control block
`default_nettype none
package clkm_pkg;
    localparam logic [7:0] CTRL_ADDR      = 8'hB9;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam int         ON_BIT         = 7;
    localparam int         INIT_BIT       = 6;
    localparam int         LOCKED_BIT     = 5;
    localparam int         SEL_LSB        = 0;
    localparam int         SEL_W          = 2;
    localparam logic [1:0] SRC_INT_OSC    = 2'h0;
    localparam logic [1:0] SRC_EXT_OSC    = 2'h1;
    localparam logic [1:0] SRC_EXT_HALF   = 2'h2;
    localparam logic [1:0] SRC_RESERVED   = 2'h3;
    localparam logic [2:0] MUL_FACTOR     = 3'h4;
    localparam int         REF_FREQ_MHZ   = 12;
    localparam int         CLK_FREQ_MHZ   = 250;
    localparam int         LOCK_TIME_NS   = 2000;
    localparam int         LOCK_CYCLES    = (LOCK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam logic [1:0] SYS_REQ_OTHER  = 2'h0;
    localparam logic [1:0] SYS_REQ_HALF   = 2'h1;
    localparam logic [1:0] SYS_REQ_FULL   = 2'h2;
    localparam logic [1:0] SYS_SEL_NONE   = 2'h0;
    localparam logic [1:0] SYS_SEL_HALF   = 2'h1;
    localparam logic [1:0] SYS_SEL_FULL   = 2'h2;
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_ARMED   = 4'h2,
        ST_LOCKING = 4'h4,
        ST_LOCKED  = 4'h8
    } clkm_state_type;
endpackage
`default_nettype wire

// *** test/clkm_sw_model.sv ***
// Software-side register master model for the clock multiplier bench
`default_nettype none
module clkm_sw_model #(
    parameter int SETTLE = 1251
) (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] sfr_rdata_i,
    output logic      [7:0] sfr_addr_o,
    output logic            sfr_wr_o,
    output logic      [7:0] sfr_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sfr_addr_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_wdata_o = 8'h00;
    end
    // One write: held from a falling edge through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_addr_o <= a;
        sfr_wdata_o <= d;
        sfr_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sfr_wr_o <= 1'b0;
        sfr_wdata_o <= ~d;
    endtask
    // Read data is registered one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_addr_o <= a;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        d = sfr_rdata_i;
    endtask
    // Reference assumed running; wait past 5 us before init
    task automatic settle();
        repeat (SETTLE) @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

// *** test/clock_multiplier_4x_bench.sv ***
// Self-checking bench for the clock multiplier control block
`default_nettype none
module clock_multiplier_4x_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LK = 6;
    logic       sys_clk_i;
    logic       reset_i;
    logic [7:0] sfr_addr_i;
    logic       sfr_wr_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic [1:0] sysclk_req_i;
    logic       mul_on_o;
    logic [1:0] mul_ref_sel_o;
    logic       mul_ref_half_o;
    logic [2:0] mul_factor_o;
    logic       mul_locked_o;
    logic [1:0] sysclk_mul_sel_o;
    int err_count = 0;
    int compares = 0;
    int m_on = 0, m_init = 0, m_lk = 0, m_sel = 0, n;
    logic [31:0] seed = 32'h9B30;
    logic [7:0] d;
    logic [1:0] r;
    clkm_ctrl #(.LOCK_CYCLES(LK), .FULL_SYSCLK_EN(1'b1)) DUT (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .sysclk_req_i(sysclk_req_i), .mul_on_o(mul_on_o), .mul_ref_sel_o(mul_ref_sel_o),
        .mul_ref_half_o(mul_ref_half_o), .mul_factor_o(mul_factor_o),
        .mul_locked_o(mul_locked_o), .sysclk_mul_sel_o(sysclk_mul_sel_o));
    clkm_sw_model sw (
        .sys_clk_i(sys_clk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
        .sfr_wr_o(sfr_wr_i), .sfr_wdata_o(sfr_wdata_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Write through the master model, update the model, compare outputs
    task automatic w(input logic [7:0] v);
        logic st;
        st = m_on[0] && v[7] && v[6] && v[1:0] != 2'h3;
        sw.wr(8'hB9, v);
        m_on = v[7];
        m_init = v[6];
        m_sel = v[1:0];
        if (!v[7] || st) m_lk = 0;
        chk("fields", {m_on[0], m_sel[1:0], m_sel == 2, m_lk[0], 3'h4},
            {mul_on_o, mul_ref_sel_o, mul_ref_half_o, mul_locked_o, mul_factor_o});
    endtask
    task automatic wait_lock(input int exp_lock);
        n = 0;
        while (mul_locked_o !== 1'b1 && n < 12) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (exp_lock != 0) m_lk = 1;
        chk("lock time", exp_lock != 0 ? 8'(n >= LK - 1 && n <= LK + 1) : 8'(n == 12), 8'h01);
        chk("locked", m_lk, mul_locked_o);
    endtask
    initial begin
        reset_i = 1'b1;
        sysclk_req_i = 2'h0;
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i <= 1'b0;
        sw.rd(8'hB9, d);
        chk("reset read", 8'h00, d);
        chk("factor", 8'h04, mul_factor_o);
        for (int s = 0; s < 4; s++) begin
            r = xs();
            w(8'h00);
            w(8'(s));
            w(8'h80 | 8'(s));
            sw.settle();
            w({2'h3, 1'b0, 3'(xs()), 2'(s)});
            wait_lock(s != 3);
            if (s != 3) begin
                sw.rd(8'hB9, d);
                chk("read", {m_on[0], m_init[0], m_lk[0], 3'h0, m_sel[1:0]}, d);
            end
        end
        w(8'h81);
        w(8'hC1);
        wait_lock(1);
        w(8'hC1);
        chk("relock clear", 8'h00, mul_locked_o);
        wait_lock(1);
        @(negedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(negedge sys_clk_i);
        reset_i <= 1'b0;
        m_on = 0;
        m_init = 0;
        m_lk = 0;
        m_sel = 0;
        chk("mid reset", 8'h04,
            {mul_on_o, mul_ref_sel_o, mul_ref_half_o, mul_locked_o, mul_factor_o});
        w(8'h01);
        chk("off clear", 8'h00, mul_locked_o);
        w(8'h41);
        wait_lock(0);
        sw.wr(8'hB8, 8'h81);
        chk("unmapped wr", 8'h00, mul_on_o);
        sw.rd(8'hB8, d);
        chk("unmapped rd", 8'h00, d);
        repeat (20) begin
            @(negedge sys_clk_i);
            r = 2'(xs());
            sysclk_req_i <= r;
            @(negedge sys_clk_i);
            chk("sysclk sel", (r == 2'h3) ? 8'h00 : 8'(r), sysclk_mul_sel_o);
        end
        tally_and_finish();
    end
    initial begin
        #60000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
